//--- design/rirl_pkg.sv
// Constants and types of the reset and interrupt request logic
// Behaviour
// - Reset overrides all arbitration, acts at once
// - Maskable interrupts stay off after reset
// - Pin reset or watchdog timeout: full reset
// - External pins gated by enable and core mask
// - Peripheral events gated by enable and core mask
// - Soft instruction branches to operand, sets mask
// - Nonmaskable instruction branches 24h, sets mask
// - Vector 22h instruction leaves mask untouched
// - Emulator trap reachable through software instructions
// - Hardware requests share the first two of six core lines
// - Each source has its own vector code
// - Reset vectors to 0000h, highest priority
// - Power protect a/b flags, codes, first line
// - Timer 1 compare at 0.13, 0028h, line two
package rirl_pkg;
	localparam int RIRL_NSRC = 23;
	localparam int RIRL_NLINE = 6;
	localparam int RIRL_RST_HOLD = 4;
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_EMU = 16'h0026;
	localparam logic [15:0] VEC_NMI = 16'h0024;
	localparam logic [15:0] VEC_TRAP = 16'h0022;
	// Lines three to six carry no source yet
	localparam logic [5:0][15:0] LINE_VEC = {16'h000c, 16'h000a, 16'h0008, 16'h0006, 16'h0004, 16'h0002};
	// Tables below run from source 22 down to source 0
	localparam logic [22:0][2:0] SRC_LINE = {{13{3'h1}}, {10{3'h0}}};
	localparam logic [22:0][15:0] SRC_PIV = {16'h0031, 16'h0030, 16'h002f, 16'h0026, 16'h0025, 16'h0024,
		16'h002a, 16'h0029, 16'h0028, 16'h0027, 16'h0023, 16'h0022, 16'h0021, 16'h0041, 16'h0040,
		16'h0007, 16'h0006, 16'h0005, 16'h0011, 16'h0001, 16'h0004, 16'h0019, 16'h0020};
	// Flag position: group in bit 5, bit number in bits 3..0
	localparam logic [22:0][7:0] SRC_FLAG = {8'h26, 8'h25, 8'h24, 8'h23, 8'h22, 8'h21, 8'h0f, 8'h0e,
		8'h0d, 8'h0c, 8'h0b, 8'h0a, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01,
		8'h20, 8'h00};
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_CMASK = 5'h04;
	localparam logic [4:0] REG_SRCEN = 5'h08;
	localparam logic [4:0] REG_PEND = 5'h0c;
	localparam logic [4:0] REG_VEC = 5'h10;
	localparam logic [4:0] REG_ISTS = 5'h14;
	localparam logic [4:0] REG_IMASK = 5'h18;
	localparam int CTRL_GMF = 0;
	localparam int CTRL_SWRST = 1;
	localparam int IST_PIN = 0;
	localparam int IST_WDT = 1;
	localparam int IST_TAKE = 2;
	localparam int IST_W = 3;
	localparam logic GMF_RST = 1'b1;
	localparam logic [5:0] CMASK_RST = 6'h00;
	localparam logic [22:0] SRCEN_RST = 23'h000000;
	typedef enum logic {ST_RESET, ST_RUN} rirl_state_t;
	typedef enum logic [1:0] {RIRL_SW_SOFT_IRQ_INSTR, RIRL_SW_NMI, RIRL_SW_TRAP} rirl_sw_kind_t;
	typedef struct packed {
		logic valid;
		rirl_sw_kind_t kind;
		logic [15:0] operand;
	} rirl_sw_req_t;
	typedef struct packed {
		logic valid;
		logic [15:0] vector;
		logic mask_set;
	} rirl_branch_t;
endpackage

//--- design/rirl_prio_enc.sv
// Lowest-index-first priority encoder
`timescale 1ns/10ps
`default_nettype none
module rirl_prio_enc #(
	parameter int W = 8,
	parameter int IW = 3
) (
	// Requests
	input wire logic [W-1:0] req,
	// Winner
	output logic found,
	output logic [IW-1:0] idx
);
	import rirl_pkg::*;

	always_comb begin
		found = |req;
		idx = '0;
		for (int i = W - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = IW'(i);
			end
		end
	end
endmodule
`default_nettype wire

//--- design/rirl_reset_ctl.sv
// Reset cause combiner and hold stretcher
`timescale 1ns/10ps
`default_nettype none
module rirl_reset_ctl #(
	parameter int HOLD = rirl_pkg::RIRL_RST_HOLD
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Causes
	input wire logic ext_reset_n,
	input wire logic wdt_timeout,
	input wire logic sw_reset,
	// Result
	output logic reset_active
);
	import rirl_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
	} rirl_rctl_state_t;

	rirl_rctl_state_t s_ff;
	rirl_rctl_state_t nxt_s;
	logic cause;

	always_comb begin
		nxt_s = s_ff;
		// any of the three causes (pin, watchdog, software) is a full reset
		cause = ~ext_reset_n | wdt_timeout | sw_reset;
		// cause acts in the same cycle
		reset_active = cause | (s_ff.cnt != 8'h00);
		if (cause) begin
			nxt_s.cnt = 8'(HOLD);
		end else if (s_ff.cnt != 8'h00) begin
			nxt_s.cnt = s_ff.cnt - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_cause_now: assert property (cause |-> reset_active) else $error("reset cause not acting");
	a_hold_stretch: assert property ($fell(cause) |-> reset_active) else $error("reset not stretched");
endmodule
`default_nettype wire

//--- design/rirl_top.sv
// Reset and interrupt request logic with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
module rirl_top #(
	parameter int RST_HOLD = rirl_pkg::RIRL_RST_HOLD
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Reset causes
	input wire logic ext_reset_n,
	input wire logic wdt_timeout,
	// Hardware requests
	input wire logic ext_irq_one,
	input wire logic ext_irq_two,
	input wire logic power_protect_irq_a,
	input wire logic power_protect_irq_b,
	input wire logic [rirl_pkg::RIRL_NSRC-5:0] periph_irq,
	// Core side
	input wire rirl_pkg::rirl_sw_req_t sw_req,
	output logic core_reset,
	output logic [rirl_pkg::RIRL_NLINE-1:0] core_irq_lines,
	output rirl_pkg::rirl_branch_t branch,
	output logic [15:0] periph_vector_code,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Interrupt
	output logic irq
);
	import rirl_pkg::*;

	typedef struct packed {
		rirl_state_t st;
		logic gmf;
		logic [RIRL_NLINE-1:0] cmask;
		logic [RIRL_NSRC-1:0] srcen;
		logic [RIRL_NSRC-1:0] pend;
		logic [15:0] peripheral_vector_code;
		logic [IST_W-1:0] ists;
		logic [IST_W-1:0] imask;
		logic ack;
		logic [31:0] rdata;
		rirl_branch_t br;
	} rirl_top_state_t;

	rirl_top_state_t s_ff;
	rirl_top_state_t nxt_s;
	logic reset_active;
	logic sw_rst_req;
	logic bus_req;
	logic fire;
	logic wr_ctrl;
	logic [RIRL_NSRC-1:0] src;
	logic [RIRL_NSRC-1:0] clr;
	logic [31:0] pend_view;
	logic [31:0] rd_mux;
	logic [31:0] wmerge;
	logic [RIRL_NLINE-1:0] line_found;
	logic [RIRL_NLINE-1:0][4:0] line_idx;
	logic any_line;
	logic [2:0] sel_line;
	logic take;
	logic [4:0] take_idx;
	logic [15:0] take_piv;
	logic [IST_W-1:0] ev;

	function automatic rirl_top_state_t rst_state();
		rirl_top_state_t r;
		r = '0;
		r.st = ST_RESET;
		r.gmf = GMF_RST;
		r.cmask = CMASK_RST;
		r.srcen = SRCEN_RST;
		return r;
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				m[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return m;
	endfunction

	function automatic logic [RIRL_NSRC-1:0] on_line(input int l);
		logic [RIRL_NSRC-1:0] m;
		m = '0;
		for (int i = 0; i < RIRL_NSRC; i++) begin
			m[i] = (SRC_LINE[i] == 3'(l));
		end
		return m;
	endfunction

	//****************************************
	// Reset causes
	//****************************************
	rirl_reset_ctl #(
		.HOLD(RST_HOLD)
	) u_reset (
		.clk(clk),
		.rst(rst),
		.ext_reset_n(ext_reset_n),
		.wdt_timeout(wdt_timeout),
		.sw_reset(sw_rst_req),
		.reset_active(reset_active)
	);

	assign core_reset = rst | reset_active;

	//****************************************
	// Request grouping onto core lines
	//****************************************
	// external pins join the shared source vector
	assign src = {periph_irq[RIRL_NSRC-5:1], ext_irq_two, ext_irq_one, periph_irq[0],
		power_protect_irq_b, power_protect_irq_a};

	// each line owns a priority slice of the sources
	for (genvar l = 0; l < RIRL_NLINE; l++) begin : g_line
		rirl_prio_enc #(
			.W(RIRL_NSRC),
			.IW(5)
		) u_enc (
			.req(s_ff.pend & s_ff.srcen & on_line(l)),
			.found(line_found[l]),
			.idx(line_idx[l])
		);
		// per-event enable and core mask both gate
		assign core_irq_lines[l] = line_found[l] & s_ff.cmask[l];
	end

	rirl_prio_enc #(
		.W(RIRL_NLINE),
		.IW(3)
	) u_line_enc (
		.req(core_irq_lines),
		.found(any_line),
		.idx(sel_line)
	);

	//****************************************
	// Register view
	//****************************************
	always_comb begin
		pend_view = '0;
		// flags sit at their group.bit positions
		for (int i = 0; i < RIRL_NSRC; i++) begin
			pend_view[{SRC_FLAG[i][5], SRC_FLAG[i][3:0]}] = s_ff.pend[i];
		end
	end

	always_comb begin
		case (avs_address)
			REG_CTRL: rd_mux = {31'h00000000, s_ff.gmf};
			REG_CMASK: rd_mux = {26'h0000000, s_ff.cmask};
			REG_SRCEN: rd_mux = {9'h000, s_ff.srcen};
			REG_PEND: rd_mux = pend_view;
			REG_VEC: rd_mux = {16'h0000, s_ff.peripheral_vector_code};
			REG_ISTS: rd_mux = {29'h00000000, s_ff.ists};
			REG_IMASK: rd_mux = {29'h00000000, s_ff.imask};
			default: rd_mux = 32'h00000000;
		endcase
	end

	assign bus_req = avs_read | avs_write;
	// One wait cycle: data are registered before the answer
	assign avs_waitrequest = bus_req & ~s_ff.ack;
	assign fire = bus_req & s_ff.ack;
	assign wr_ctrl = fire & avs_write & (avs_address == REG_CTRL);
	assign sw_rst_req = wr_ctrl & avs_byteenable[0] & avs_writedata[CTRL_SWRST];
	assign avs_readdata = s_ff.rdata;
	assign irq = |(s_ff.ists & s_ff.imask);
	assign branch = s_ff.br;
	assign periph_vector_code = s_ff.peripheral_vector_code;

	//****************************************
	// Acknowledge selection
	//****************************************
	assign take = ~s_ff.gmf & any_line & ~sw_req.valid & (s_ff.st == ST_RUN);
	assign take_idx = line_idx[sel_line];
	// vector code picked per source, not per line
	assign take_piv = SRC_PIV[take_idx];

	//****************************************
	// Next state
	//****************************************
	always_comb begin
		nxt_s = s_ff;
		nxt_s.br = '0;
		wmerge = be_merge(rd_mux, avs_writedata, avs_byteenable);
		nxt_s.ack = bus_req & ~s_ff.ack;
		if (bus_req & ~s_ff.ack) begin
			nxt_s.rdata = rd_mux;
		end
		if (fire & avs_write) begin
			case (avs_address)
				REG_CTRL: nxt_s.gmf = wmerge[CTRL_GMF];
				REG_CMASK: nxt_s.cmask = wmerge[RIRL_NLINE-1:0];
				REG_SRCEN: nxt_s.srcen = wmerge[RIRL_NSRC-1:0];
				REG_IMASK: nxt_s.imask = wmerge[IST_W-1:0];
				default: nxt_s.imask = s_ff.imask;
			endcase
		end
		// only the taken source loses its flag
		clr = '0;
		if (take) begin
			clr[take_idx] = 1'b1;
		end
		// New events win over the acknowledge clear
		nxt_s.pend = (s_ff.pend & ~clr) | src;
		ev = '0;
		ev[IST_TAKE] = take;
		// Only bits that were reported are cleared, late events survive
		if (fire & avs_read & (avs_address == REG_ISTS)) begin
			nxt_s.ists = (s_ff.ists & ~s_ff.rdata[IST_W-1:0]) | ev;
		end else begin
			nxt_s.ists = s_ff.ists | ev;
		end
		if (s_ff.st == ST_RESET) begin
			// first action after reset is vector 0000h
			nxt_s.br = '{valid: 1'b1, vector: VEC_RESET, mask_set: 1'b1};
			nxt_s.st = ST_RUN;
		end else if (sw_req.valid) begin
			case (sw_req.kind)
				RIRL_SW_SOFT_IRQ_INSTR: begin
					// branch to operand and set the mask
					// operand VEC_EMU raises the emulator trap
					nxt_s.br = '{valid: 1'b1, vector: sw_req.operand, mask_set: 1'b1};
					nxt_s.gmf = 1'b1;
				end
				RIRL_SW_NMI: begin
					nxt_s.br = '{valid: 1'b1, vector: VEC_NMI, mask_set: 1'b1};
					nxt_s.gmf = 1'b1;
				end
				RIRL_SW_TRAP: begin
					// mask left as it was so hardware can preempt
					nxt_s.br = '{valid: 1'b1, vector: VEC_TRAP, mask_set: 1'b0};
				end
				default: nxt_s.br = '0;
			endcase
		end else if (take) begin
			nxt_s.br = '{valid: 1'b1, vector: LINE_VEC[sel_line], mask_set: 1'b1};
			nxt_s.gmf = 1'b1;
			nxt_s.peripheral_vector_code = take_piv;
		end
		if (reset_active) begin
			// masks return to their disabled state
			nxt_s = rst_state();
			nxt_s.ists = s_ff.ists;
			nxt_s.ists[IST_PIN] = s_ff.ists[IST_PIN] | ~ext_reset_n;
			nxt_s.ists[IST_WDT] = s_ff.ists[IST_WDT] | wdt_timeout;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_ff <= rst_state();
		end else begin
			s_ff <= nxt_s;
		end
	end

	//****************************************
	// Checks
	//****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_reset_vector: assert property (!reset_active && $past(reset_active) |=> branch.valid &&
		branch.vector == VEC_RESET) else $error("reset vector missing");
	a_reset_first: assert property (reset_active |=> !branch.valid) else $error("branch during reset");
	a_reset_masks: assert property (reset_active |=> s_ff.gmf && s_ff.cmask == CMASK_RST &&
		s_ff.srcen == SRCEN_RST) else $error("masks not disabled after reset");
	a_cause_full: assert property ((!ext_reset_n || wdt_timeout) |-> core_reset) else $error("cause ignored");
	a_line_gate: assert property (core_irq_lines[0] |-> s_ff.cmask[0] &&
		(s_ff.pend & s_ff.srcen) != '0) else $error("line raised while gated");
	a_pin_gate: assert property (!s_ff.srcen[0] && !s_ff.srcen[1] && !s_ff.srcen[3] && !s_ff.srcen[4] &&
		s_ff.srcen[22:5] == '0 && !s_ff.srcen[2] |-> core_irq_lines == '0) else $error("disabled pin reached core");
	a_protect_a: assert property (take && !reset_active && sel_line == 3'h0 && s_ff.pend[0] &&
		s_ff.srcen[0] |=> periph_vector_code == SRC_PIV[0] && branch.vector == LINE_VEC[0])
		else $error("protect a code");
	a_t1c_map: assert property (take && !reset_active && sel_line == 3'h1 && take_idx == 5'd14 |=>
		periph_vector_code == SRC_PIV[14] && branch.vector == LINE_VEC[1]) else $error("timer compare code");
	a_t1c_flag: assert property (pend_view[13] == s_ff.pend[14]) else $error("timer flag position");
	a_soft_soft_irq_instr: assert property (sw_req.valid && sw_req.kind == RIRL_SW_SOFT_IRQ_INSTR && !reset_active &&
		s_ff.st == ST_RUN |=> branch.vector == $past(sw_req.operand) && s_ff.gmf) else $error("soft irq");
	a_soft_nmi: assert property (sw_req.valid && sw_req.kind == RIRL_SW_NMI && !reset_active &&
		s_ff.st == ST_RUN |=> branch.valid && branch.vector == VEC_NMI && s_ff.gmf) else $error("nmi");
	a_trap_keep: assert property (sw_req.valid && sw_req.kind == RIRL_SW_TRAP && !reset_active &&
		s_ff.st == ST_RUN && !wr_ctrl |=> branch.vector == VEC_TRAP && s_ff.gmf == $past(s_ff.gmf))
		else $error("trap changed mask");
	a_take_latch: assert property (take && !reset_active |=> s_ff.gmf && branch.valid &&
		periph_vector_code == $past(take_piv)) else $error("acknowledge latch");
	a_bus_answer: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
		else $error("bus answer late");

	c_reset_branch: cover property (s_ff.st == ST_RESET ##1 branch.valid);
	c_hw_take: cover property (take ##1 branch.valid);
	c_trap_preempt: cover property (sw_req.valid && sw_req.kind == RIRL_SW_TRAP ##[1:20] take);
	c_status_read: cover property (fire && avs_read && avs_address == REG_ISTS && s_ff.rdata != '0);
endmodule
`default_nettype wire

//--- test/rirl_core_model.sv
// Core-side model: issues software instructions and records branches
`timescale 1ns/10ps
`default_nettype none
module rirl_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Instruction command from the bench
	input wire logic go,
	input wire logic [1:0] go_kind,
	input wire logic [15:0] go_op,
	// Block side
	output rirl_pkg::rirl_sw_req_t sw_req,
	input wire rirl_pkg::rirl_branch_t branch,
	// Last branch seen
	output logic [15:0] seen_vec,
	output logic seen_mask,
	output logic [15:0] seen_cnt
);
	import rirl_pkg::*;
	// ****************
	// Instruction issue
	// ****************
	// one instruction per command
	always @(posedge clk) begin
		if (!rst && go) begin
			sw_req <= '{valid: 1'b1, kind: rirl_sw_kind_t'(go_kind), operand: go_op};
		end else begin
			sw_req <= '0;
		end
	end
	// Branches are one-cycle pulses, so count every one
	always @(posedge clk) begin
		if (rst) begin
			seen_cnt <= 16'h0000;
		end else if (branch.valid === 1'b1) begin
			seen_vec <= branch.vector;
			seen_mask <= branch.mask_set;
			seen_cnt <= seen_cnt + 16'h0001;
		end
	end
endmodule
`default_nettype wire

//--- test/rirl_top_bench.sv
// Self-checking bench of the reset and interrupt request logic
`timescale 1ns/10ps
`default_nettype none
module rirl_top_bench;
	import rirl_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ext_reset_n = 1'b1;
	logic wdt_timeout = 1'b0;
	logic go = 1'b0;
	logic [1:0] go_kind = 2'h0;
	logic [15:0] go_op = 16'h0000;
	logic [22:0] ev = 23'h000000;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, core_reset, irq, seen_mask;
	logic [5:0] core_irq_lines;
	logic [15:0] periph_vector_code, seen_vec, seen_cnt, c0;
	rirl_sw_req_t sw_req;
	rirl_branch_t branch;
	int miscompares = 0;
	int checked = 0;
	int seed = 85;
	int s;
	always #10 clk = ~clk;
	rirl_top rirl_top_inst (.clk(clk), .rst(rst), .ext_reset_n(ext_reset_n), .wdt_timeout(wdt_timeout),
		.ext_irq_one(ev[3]), .ext_irq_two(ev[4]), .power_protect_irq_a(ev[0]), .power_protect_irq_b(ev[1]),
		.periph_irq({ev[22:5], ev[2]}), .sw_req(sw_req), .core_reset(core_reset),
		.core_irq_lines(core_irq_lines), .branch(branch), .periph_vector_code(periph_vector_code),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq(irq));
	rirl_core_model rirl_core_model_inst (.clk(clk), .rst(rst), .go(go), .go_kind(go_kind), .go_op(go_op),
		.sw_req(sw_req), .branch(branch), .seen_vec(seen_vec), .seen_mask(seen_mask), .seen_cnt(seen_cnt));
	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic results();
		$display("Counts: %0d compares, %0d mismatches", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		n = 0;
		// Taken at the edge where waitrequest is seen low
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		if (n >= 40) begin
			miscompares++;
			results();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// Caller sets c0 before the trigger, so a quick branch is not missed
	task automatic wait_br();
		int n;
		n = 0;
		while (seen_cnt === c0 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 40) begin
			miscompares++;
			results();
		end
	endtask
	task automatic sw(input logic [1:0] k, input logic [15:0] op, input logic [15:0] ev_vec);
		c0 = seen_cnt;
		@(posedge clk);
		go <= 1'b1;
		go_kind <= k;
		go_op <= op;
		@(posedge clk);
		go <= 1'b0;
		wait_br();
		chk({16'h0, seen_vec}, {16'h0, ev_vec});
	endtask
	task automatic pulse(input logic [22:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 23'h0;
	endtask
	task automatic take(input logic [15:0] v, input logic [15:0] code);
		c0 = seen_cnt;
		bus(1'b1, REG_CTRL, 32'h0);
		wait_br();
		chk({16'h0, seen_vec}, {16'h0, v});
		chk({16'h0, periph_vector_code}, {16'h0, code});
	endtask
	task automatic hw(input int n);
		pulse(23'h1 << n);
		#1;
		chk({31'h0, core_irq_lines[n >= 10]}, 32'h1);
		take((n < 10) ? 16'h0002 : 16'h0004, SRC_PIV[n]);
		rdc(REG_PEND, 32'h0);
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		c0 = 16'h0000;
		wait_br();
		chk({16'h0, seen_vec}, 32'h0);
		chk({31'h0, seen_mask}, 32'h1);
		rdc(REG_CTRL, 32'h1);
		rdc(REG_CMASK, 32'h0);
		rdc(REG_SRCEN, 32'h0);
		rdc(5'h1c, 32'h0);
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, REG_CMASK, 32'h3f);
			c0 = seen_cnt;
			@(posedge clk);
			ext_reset_n <= (i != 0);
			wdt_timeout <= (i == 1);
			#1;
			chk({31'h0, core_reset}, 32'h1);
			@(posedge clk);
			ext_reset_n <= 1'b1;
			wdt_timeout <= 1'b0;
			wait_br();
			chk({16'h0, seen_vec}, 32'h0);
			rdc(REG_CMASK, 32'h0);
			rdc(REG_ISTS, 32'h1 << i);
		end
		$display("Test reset causes done");
		bus(1'b1, REG_CTRL, 32'h0);
		sw(2'h2, 16'h0, 16'h0022);
		chk({31'h0, seen_mask}, 32'h0);
		rdc(REG_CTRL, 32'h0);
		sw(2'h1, 16'h0, 16'h0024);
		rdc(REG_CTRL, 32'h1);
		bus(1'b1, REG_CTRL, 32'h0);
		sw(2'h0, 16'h0026, 16'h0026);
		rdc(REG_CTRL, 32'h1);
		s = $random(seed);
		sw(2'h0, s[15:0], s[15:0]);
		chk({31'h0, seen_mask}, 32'h1);
		$display("Test software instructions done");
		bus(1'b1, REG_IMASK, 32'h4);
		bus(1'b1, REG_SRCEN, 32'h7fbfff);
		bus(1'b1, REG_CMASK, 32'h3e);
		pulse(23'h004008);
		c0 = seen_cnt;
		bus(1'b1, REG_CTRL, 32'h0);
		repeat (4) @(posedge clk);
		#1;
		chk({26'h0, core_irq_lines}, 32'h0);
		chk({16'h0, seen_cnt}, {16'h0, c0});
		bus(1'b1, REG_SRCEN, 32'h7fffff);
		wait_br();
		chk({16'h0, seen_vec}, 32'h4);
		chk({16'h0, periph_vector_code}, 32'h28);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, REG_CMASK, 32'h3f);
		take(16'h0002, 16'h0001);
		rdc(REG_ISTS, 32'h4);
		#1;
		chk({31'h0, irq}, 32'h0);
		pulse(23'h000003);
		take(16'h0002, 16'h0020);
		take(16'h0002, 16'h0019);
		$display("Test masking and priority done");
		repeat (8) begin
			s = $unsigned($random(seed)) % 23;
			hw(s);
		end
		$display("Test random sources done");
		results();
	end
endmodule
`default_nettype wire
